// ===== purs_sequencer.sv
// Power-up reset sequencer with reset cause flags on a Wishbone slave
//
// What this block does
// - Power-up delay gives 72 ms, started only by power-on or brown-out reset.
// - Chip stays in reset the whole time the power-up delay runs.
// - Power-up delay config bit set disables the delay; cleared enables it.
// - Power-up delay counts the internal RC clock, never the oscillator input.
// - Oscillator start-up adds 1024 oscillator input cycles after the power-up delay.
// - Oscillator start-up applies only in crystal modes, on power-on, brown-out or wake.
// - Crystal modes: 72 ms plus 1024 cycles, or 1024 cycles when delay off/wake.
// - RC mode: 72 ms on enabled power-up and brown-out, otherwise no delay.
// - Brown-out enable config bit set enables brown-out reset; cleared disables it.
// - Only supply dips longer than the least brown-out duration reset the chip.
// - After a brown-out reset, wait for supply above threshold, then 72 ms more.
// - Supply dip during the power-up delay re-enters brown-out and restarts it.
// - Power-up order: power-on reset, then power-up delay, then oscillator start-up.
// - Delays run regardless of reset pin; late pin release starts at once.
// - Power-on detection acts only on supply rise, never on supply fall.
// - Bits 7 to 2 of the reset cause flags register read as zero.
// - Power-on flag clears on power-on reset only; software may write it.
// - Brown-out flag clears on brown-out reset; software sets it afterwards.
// - Brown-out flag is a don't-care while brown-out reset is disabled.
//
// The Wishbone interface to the registers was decided locally.
`include "purs_params.svh"
`default_nettype none

module purs_sequencer #(
	parameter int unsigned PWRUP_CYCLES = `PURS_PWRUP_DLY_MS * `PURS_CLK_KHZ
) (
	// Clock and power-on reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Configuration word
	input wire logic power_up_delay_enable_cfg_i,
	input wire logic brown_out_enable_cfg_i,
	input wire logic [1:0] osc_mode_i,
	// Pins and detectors
	input wire logic external_reset_pin_n_i,
	input wire logic oscillator_input_pin_i,
	input wire logic supply_below_threshold_i,
	// Core side
	input wire logic wake_event_i,
	output logic core_reset_o,
	output logic core_hold_o
);

	localparam int unsigned BOR_CYC = (`PURS_BOR_MIN_US * `PURS_CLK_KHZ + 999) / 1000;
	localparam logic [21:0] PWRUP_LAST = 22'(PWRUP_CYCLES - 1);
	localparam logic [10:0] START_LAST = 11'(`PURS_START_OSC_CYC - 1);
	localparam logic [11:0] BOR_LAST = 12'(BOR_CYC - 1);

	purs_pkg::purs_state_t state_r, state_nxt;
	purs_pkg::purs_cause_t cause_r, cause_nxt;
	logic [2:0] sync1_r, sync2_r, sync3_r, filt_r;
	logic osc_prev_r;
	logic osc_rise;
	logic [21:0] pwrup_cnt_r;
	logic [10:0] start_cnt_r;
	logic [11:0] bor_cnt_r;
	logic supply_low, bor_trip, bor_event;
	logic pwrup_done, start_done, wake_go;
	logic sleep_r;
	logic [`PURS_FLAGS_W-1:0] flags_r;
	logic wb_ack_r;
	logic [31:0] wb_dat_r;
	logic wb_req, wr_en;
	logic core_reset_r, core_hold_r;
	logic pin_rst_n, pin_osc, pin_low;

	// Crystal or resonator oscillator mode
	function automatic logic is_crystal(input logic [1:0] mode);
		return mode != purs_pkg::PURS_OSC_RC;
	endfunction

	// Register index from a byte address
	function automatic logic [7:0] reg_index(input logic [9:0] adr);
		return adr[9:2];
	endfunction

	// Pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 3'h1;
			sync2_r <= 3'h1;
			sync3_r <= 3'h1;
			filt_r <= 3'h1;
		end else begin
			sync1_r <= {supply_below_threshold_i, oscillator_input_pin_i, external_reset_pin_n_i};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
		end
	end

	assign pin_rst_n = filt_r[0];
	assign pin_osc = filt_r[1];
	assign pin_low = filt_r[2];

	// Oscillator input edge detect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_prev_r <= 1'h0;
		end else begin
			osc_prev_r <= pin_osc;
		end
	end

	assign osc_rise = pin_osc & ~osc_prev_r;

	// Brown-out detection only when enabled
	assign supply_low = brown_out_enable_cfg_i & pin_low;

	// Dip length filter, counting only in the run and oscillator start-up states
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bor_cnt_r <= 12'h0;
		end else if (supply_low && (state_r == purs_pkg::PURS_S_RUN ||
				state_r == purs_pkg::PURS_S_OSC_START) && bor_cnt_r != BOR_LAST) begin
			bor_cnt_r <= bor_cnt_r + 12'h1;
		end else if (!supply_low) begin
			bor_cnt_r <= 12'h0;
		end
	end

	// Short dips never reach the last count
	assign bor_trip = supply_low && bor_cnt_r == BOR_LAST;

	// Power-up delay counter on the internal RC-derived clock
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r != purs_pkg::PURS_S_PWRUP_DLY) begin
			pwrup_cnt_r <= 22'h0;
		end else begin
			pwrup_cnt_r <= pwrup_cnt_r + 22'h1;
		end
	end

	assign pwrup_done = pwrup_cnt_r == PWRUP_LAST;

	// Oscillator start-up counter of oscillator input cycles
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r != purs_pkg::PURS_S_OSC_START) begin
			start_cnt_r <= 11'h0;
		end else if (osc_rise) begin
			start_cnt_r <= start_cnt_r + 11'h1;
		end
	end

	assign start_done = osc_rise && start_cnt_r == START_LAST;
	assign wake_go = sleep_r & wake_event_i;

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		bor_event = 1'b0;
		unique case (state_r)
			purs_pkg::PURS_S_WAIT_SUPPLY: begin
				if (!supply_low) begin
					if (cause_r == purs_pkg::PURS_C_BOR ||
							(cause_r == purs_pkg::PURS_C_PON &&
							!power_up_delay_enable_cfg_i)) begin
						state_nxt = purs_pkg::PURS_S_PWRUP_DLY;
					end else if (is_crystal(osc_mode_i)) begin
						state_nxt = purs_pkg::PURS_S_OSC_START;
					end else begin
						state_nxt = purs_pkg::PURS_S_RUN;
					end
				end
			end
			purs_pkg::PURS_S_PWRUP_DLY: begin
				if (supply_low) begin
					state_nxt = purs_pkg::PURS_S_WAIT_SUPPLY;
					cause_nxt = purs_pkg::PURS_C_BOR;
					bor_event = 1'b1;
				end else if (pwrup_done) begin
					if (is_crystal(osc_mode_i)) begin
						state_nxt = purs_pkg::PURS_S_OSC_START;
					end else begin
						state_nxt = purs_pkg::PURS_S_RUN;
					end
				end
			end
			purs_pkg::PURS_S_OSC_START: begin
				if (start_done) begin
					state_nxt = purs_pkg::PURS_S_RUN;
				end
			end
			purs_pkg::PURS_S_RUN: begin
				if (wake_go) begin
					cause_nxt = purs_pkg::PURS_C_WAKE;
					if (is_crystal(osc_mode_i)) begin
						state_nxt = purs_pkg::PURS_S_OSC_START;
					end
				end
			end
		endcase
		if (bor_trip && (state_r == purs_pkg::PURS_S_RUN ||
				state_r == purs_pkg::PURS_S_OSC_START)) begin
			state_nxt = purs_pkg::PURS_S_WAIT_SUPPLY;
			cause_nxt = purs_pkg::PURS_C_BOR;
			bor_event = 1'b1;
		end
	end

	// Sequencer state; only the power-on reset starts a power-on sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= purs_pkg::PURS_S_WAIT_SUPPLY;
			cause_r <= purs_pkg::PURS_C_PON;
		end else begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
		end
	end

	// Core reset and clock hold outputs, straight from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_r <= 1'b1;
			core_hold_r <= 1'b0;
		end else begin
			core_reset_r <= (state_r != purs_pkg::PURS_S_RUN &&
				cause_r != purs_pkg::PURS_C_WAKE) || !pin_rst_n;
			core_hold_r <= sleep_r || (state_r == purs_pkg::PURS_S_OSC_START &&
				cause_r == purs_pkg::PURS_C_WAKE);
		end
	end

	assign core_reset_o = core_reset_r;
	assign core_hold_o = core_hold_r;

	// Wishbone request decode
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
	assign wr_en = wb_req & wb_we_i & wb_sel_i[0];

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_r <= 1'b0;
		end else begin
			wb_ack_r <= wb_req;
		end
	end

	// Read data; unmapped indices read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_r <= 32'h0;
		end else if (wb_req && !wb_we_i) begin
			unique case (reg_index(wb_adr_i))
				`PURS_IDX_FLAGS: wb_dat_r <= {30'h0, flags_r};
				`PURS_IDX_SEQ_STATUS: wb_dat_r <= {25'h0, cause_r, state_r};
				`PURS_IDX_CTRL: wb_dat_r <= {31'h0, sleep_r};
				default: wb_dat_r <= 32'h0;
			endcase
		end else begin
			wb_dat_r <= 32'h0;
		end
	end

	assign wb_ack_o = wb_ack_r;
	assign wb_dat_o = wb_dat_r;

	// Reset cause flags; a brown-out wins over a same-cycle write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= `PURS_FLAGS_RESET;
		end else begin
			if (wr_en && reg_index(wb_adr_i) == `PURS_IDX_FLAGS) begin
				flags_r <= wb_dat_i[`PURS_FLAGS_W-1:0];
			end
			if (bor_event) begin
				flags_r[`PURS_FLAG_BOR_BIT] <= 1'b0;
			end
		end
	end

	// Sleep request; a wake event clears it
	always_ff @(posedge clk_i) begin
		if (rst_i || bor_event) begin
			sleep_r <= `PURS_CTRL_RESET;
		end else if (wake_go) begin
			sleep_r <= 1'b0;
		end else if (wr_en && reg_index(wb_adr_i) == `PURS_IDX_CTRL) begin
			sleep_r <= wb_dat_i[`PURS_CTRL_SLEEP_BIT];
		end
	end

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_reset_in_pwrup;
		state_r == purs_pkg::PURS_S_PWRUP_DLY |=> core_reset_o;
	endproperty
	a_reset_in_pwrup: assert property (p_reset_in_pwrup)
		else $error("core reset low during power-up delay");

	property p_pwrup_length;
		state_r == purs_pkg::PURS_S_PWRUP_DLY && !supply_low && pwrup_cnt_r == PWRUP_LAST
			|=> state_r == purs_pkg::PURS_S_OSC_START || state_r == purs_pkg::PURS_S_RUN;
	endproperty
	a_pwrup_length: assert property (p_pwrup_length)
		else $error("power-up delay did not end at its count");

	property p_pwrup_skip;
		state_r == purs_pkg::PURS_S_WAIT_SUPPLY && cause_r == purs_pkg::PURS_C_PON
			&& power_up_delay_enable_cfg_i |=> state_r != purs_pkg::PURS_S_PWRUP_DLY;
	endproperty
	a_pwrup_skip: assert property (p_pwrup_skip)
		else $error("power-up delay ran while disabled");

	property p_start_end;
		state_r == purs_pkg::PURS_S_OSC_START && osc_rise && start_cnt_r == START_LAST
			&& !bor_trip |=> state_r == purs_pkg::PURS_S_RUN;
	endproperty
	a_start_end: assert property (p_start_end)
		else $error("oscillator start-up did not end after its count");

	property p_rc_no_start;
		$rose(state_r == purs_pkg::PURS_S_OSC_START) |-> $past(is_crystal(osc_mode_i));
	endproperty
	a_rc_no_start: assert property (p_rc_no_start)
		else $error("oscillator start-up entered in RC mode");

	property p_bor_filter;
		$rose(bor_cnt_r == BOR_LAST) |-> $past(supply_low, 1) && $past(bor_cnt_r) == BOR_LAST - 12'h1;
	endproperty
	a_bor_filter: assert property (p_bor_filter)
		else $error("brown-out filter skipped counts");

	property p_pwrup_restart;
		state_r == purs_pkg::PURS_S_PWRUP_DLY && supply_low
			|=> state_r == purs_pkg::PURS_S_WAIT_SUPPLY ##1 pwrup_cnt_r == 22'h0;
	endproperty
	a_pwrup_restart: assert property (p_pwrup_restart)
		else $error("dip during power-up delay did not restart it");

	property p_flags_upper_zero;
		wb_ack_o |-> wb_dat_o[31:`PURS_FLAGS_W] == 30'h0 || !$past(reg_index(wb_adr_i) ==
			`PURS_IDX_FLAGS);
	endproperty
	a_flags_upper_zero: assert property (p_flags_upper_zero)
		else $error("unimplemented flag bits read nonzero");

	property p_bor_flag_clear;
		bor_event |=> !flags_r[`PURS_FLAG_BOR_BIT];
	endproperty
	a_bor_flag_clear: assert property (p_bor_flag_clear)
		else $error("brown-out flag not cleared by brown-out reset");

	property p_release_at_once;
		state_r == purs_pkg::PURS_S_RUN && cause_r != purs_pkg::PURS_C_WAKE && pin_rst_n
			&& $past(!pin_rst_n) |=> !core_reset_o;
	endproperty
	a_release_at_once: assert property (p_release_at_once)
		else $error("core reset not released when reset pin rose after delays");

	property p_release_after_counters;
		$fell(core_reset_o) |-> $past(state_r, 1) == purs_pkg::PURS_S_RUN;
	endproperty
	a_release_after_counters: assert property (p_release_after_counters)
		else $error("core reset released before sequence finished");

	c_power_up_start: cover property (state_r == purs_pkg::PURS_S_OSC_START ##1
		state_r == purs_pkg::PURS_S_RUN);
	c_pwrup_restart: cover property (state_r == purs_pkg::PURS_S_PWRUP_DLY && supply_low);
	c_brown_out: cover property (bor_trip && state_r == purs_pkg::PURS_S_RUN);
	c_wake: cover property (wake_go ##1 state_r == purs_pkg::PURS_S_OSC_START);

endmodule

`default_nettype wire

// ===== purs_params.svh
// Constants of the power-up reset sequencer: timing, register map, reset values
`ifndef PURS_PARAMS_SVH
`define PURS_PARAMS_SVH

// System clock, in kHz (40 MHz, 25 ns period)
`define PURS_CLK_KHZ 40000

// Power-up delay, nominal, in ms
`define PURS_PWRUP_DLY_MS 72

// Oscillator start-up delay, in oscillator input cycles
`define PURS_START_OSC_CYC 1024

// Least brown-out dip that resets the chip, in us
`define PURS_BOR_MIN_US 100

// Register indices; byte address is four times the index
`define PURS_IDX_FLAGS 8'h8e
`define PURS_IDX_SEQ_STATUS 8'h8f
`define PURS_IDX_CTRL 8'h90

// Fields of the reset cause flags register
`define PURS_FLAG_PON_BIT 1
`define PURS_FLAG_BOR_BIT 0
`define PURS_FLAGS_W 2
`define PURS_FLAGS_RESET 2'h0

// Fields of the control register
`define PURS_CTRL_SLEEP_BIT 0
`define PURS_CTRL_RESET 1'h0

`endif

// ===== purs_pkg.sv
// Types of the power-up reset sequencer
`default_nettype none

package purs_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		PURS_S_WAIT_SUPPLY = 4'h1,
		PURS_S_PWRUP_DLY = 4'h2,
		PURS_S_OSC_START = 4'h4,
		PURS_S_RUN = 4'h8
	} purs_state_t;

	// Cause of the sequence in progress, one-hot
	typedef enum logic [2:0] {
		PURS_C_PON = 3'h1,
		PURS_C_BOR = 3'h2,
		PURS_C_WAKE = 3'h4
	} purs_cause_t;

	// Oscillator configuration
	typedef enum logic [1:0] {
		PURS_OSC_XTAL_LOW = 2'h0,
		PURS_OSC_XTAL_STD = 2'h1,
		PURS_OSC_XTAL_FAST = 2'h2,
		PURS_OSC_RC = 2'h3
	} purs_osc_mode_t;

endpackage

`default_nettype wire

// ===== purs_far_side.sv
// Model of supply detector, reset pin and oscillator
`default_nettype none

module purs_far_side #(
	parameter int HALF_NS = 130
) (
	// Clock
	input wire logic clk_i,
	// Detector, pin, oscillator
	output logic osc_o,
	output logic supply_low_o,
	output logic pin_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Free-running oscillator input, well below clk/8
	initial begin
		osc_o = 1'b0;
		forever #(HALF_NS) osc_o = ~osc_o;
	end

	// Supply good and pin released at start
	initial begin
		supply_low_o = 1'b0;
		pin_n_o = 1'b1;
	end

	// Supply dip of n clock cycles
	task dip(input int n);
		@(posedge clk_i);
		supply_low_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		supply_low_o <= 1'b0;
	endtask

	// Reset pin held low for n clock cycles
	task hold_pin(input int n);
		@(posedge clk_i);
		pin_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		pin_n_o <= 1'b1;
	endtask
endmodule

`default_nettype wire

// ===== tb_top.sv
// Testbench of the power-up reset sequencer
`include "purs_params.svh"
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 50;
	// 1024 periods of 260 ns, in 25 ns cycles
	localparam int OSC = 10650;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, core_reset_o, core_hold_o, osc, sup_low, pin_n;
	logic pwr_dis = 1'b0, bo_en = 1'b1, wake = 1'b0;
	logic [1:0] mode = 2'h3;
	logic [7:0] rnd = 8'h3c;
	logic [31:0] expq[$];
	int miscompares = 0, n_checks = 0, n, e;

	// Clock
	always #12.5 clk_i = ~clk_i;

	purs_sequencer #(.PWRUP_CYCLES(P)) DUT (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.power_up_delay_enable_cfg_i(pwr_dis), .brown_out_enable_cfg_i(bo_en),
		.osc_mode_i(mode), .external_reset_pin_n_i(pin_n),
		.oscillator_input_pin_i(osc), .supply_below_threshold_i(sup_low),
		.wake_event_i(wake), .core_reset_o(core_reset_o), .core_hold_o(core_hold_o)
	);

	purs_far_side #(.HALF_NS(130)) far (
		.clk_i(clk_i), .osc_o(osc), .supply_low_o(sup_low), .pin_n_o(pin_n)
	);

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk_dat(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chk_cnt(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask

	// Classic single Wishbone cycle, held until ack; a hang is left to the watchdog
	task wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Read with expected data noted first
	task rd(input logic [7:0] idx, input logic [31:0] x);
		expq.push_back(x);
		wb(1'b0, idx, 32'h0);
	endtask

	// Cycles until reset (or hold) output falls
	task cnt(input logic hold, output int c);
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while ((hold ? core_hold_o : core_reset_o) !== 1'b0 && c < 20000);
	endtask

	// Power-on reset with a configuration word
	task por(input logic dis, input logic [1:0] m);
		@(posedge clk_i);
		rst_i <= 1'b1;
		pwr_dis <= dis;
		mode <= m;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	// Read data monitor, oldest note first
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
			chk_dat(wb_dat_o, expq.pop_front());
		end
	end

	// Main sequence
	initial begin
		por(1'b0, 2'h3);
		cnt(1'b0, n);
		chk_cnt(n, P, P + 10);
		rd(`PURS_IDX_FLAGS, 32'h0);
		rd(`PURS_IDX_SEQ_STATUS, 32'h18);
		rd(8'h55, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			wb(1'b1, `PURS_IDX_FLAGS, {24'h0, rnd});
			rd(`PURS_IDX_FLAGS, {30'h0, rnd[1:0]});
		end
		$display("test powerup done");
		wb(1'b1, `PURS_IDX_FLAGS, 32'h3);
		far.dip(3500);
		repeat (10) @(posedge clk_i);
		chk_dat({31'h0, core_reset_o}, 32'h0);
		far.dip(4500);
		chk_dat({31'h0, core_reset_o}, 32'h1);
		repeat (20) @(posedge clk_i);
		far.dip(10);
		cnt(1'b0, n);
		chk_cnt(n, P, P + 12);
		rd(`PURS_IDX_FLAGS, 32'h2);
		$display("test brownout done");
		bo_en <= 1'b0;
		por(1'b1, 2'h3);
		cnt(1'b0, n);
		chk_cnt(n, 1, 8);
		far.dip(4500);
		chk_dat({31'h0, core_reset_o}, 32'h0);
		fork
			far.hold_pin(P + 100);
			por(1'b0, 2'h3);
		join
		cnt(1'b0, n);
		chk_cnt(n, 1, 6);
		$display("test pin done");
		for (int m = 0; m < 3; m++) begin
			por(m[0], m[1:0]);
			e = (m[0] ? 0 : P) + OSC;
			cnt(1'b0, n);
			chk_cnt(n, e - 15, e + 30);
		end
		$display("test crystal done");
		wb(1'b1, `PURS_IDX_CTRL, 32'h1);
		repeat (3) @(posedge clk_i);
		chk_dat({31'h0, core_hold_o}, 32'h1);
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
		cnt(1'b1, n);
		chk_cnt(n, OSC - 15, OSC + 30);
		chk_dat({31'h0, core_reset_o}, 32'h0);
		rd(`PURS_IDX_CTRL, 32'h0);
		$display("test wake done");
		repeat (3) @(posedge clk_i);
		close_out();
	end

	// Watchdog against a hang
	initial begin
		repeat (90000) @(posedge clk_i);
		miscompares++;
		close_out();
	end
endmodule

`default_nettype wire
